// >>> dv/parallel_program_port_entry_erase_tb_top.sv
// self-checking bench: apb driven programmer against the device model
`timescale 1ns/1ps
`include "prog_port_regs.vh"
module parallel_program_port_entry_erase_tb_top;
    reg pclk, presetn, psel, penable, pwrite, err;
    reg [7:0] paddr, b;
    reg [31:0] pwdata, rd, r;
    wire [31:0] prdata;
    wire pready, pslverr, vcc_en, reset_low, reset_hv_en, load_pulse_input, action_select_hi;
    wire action_select_lo, low_high_byte_select, page_load_strobe, write_strobe_n;
    wire output_enable_n, data_oe_n, ready_busy_flag;
    wire [7:0] data_out, data_in;
    integer fail_count, n_checks, seed, i, k, w, nl;
    prog_port_ctrl #(.ALT_WAIT_CYC(16'h0032)) uut (.*);
    prog_dev_model mdl (.*);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ***
    // bus tasks and comparison
    // ***
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp, input [8*10-1:0] what);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected %0s: expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // one apb transfer; an idle cycle follows so psel is never set twice at one edge
    task apb(input wr, input [7:0] a, input [31:0] d);
        begin
            {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && k < 20) begin
                k = k + 1;
                @(posedge pclk);
            end
            {rd, err} = {prdata, pslverr};
            {psel, penable} <= 2'h0;
            @(posedge pclk);
            if (k == 20 || w == 3000) begin
                fail_count = fail_count + 1;
                report_and_stop;
            end
        end
    endtask
    task st;
        apb(1'b0, `REG_STATUS, 32'h0);
    endtask
    task wait_idle;
        begin
            w = 0;
            st;
            while (rd[`ST_BUSY] !== 1'b0 && w < 3000) begin
                w = w + 1;
                st;
            end
        end
    endtask
    task op(input [2:0] o, input [1:0] a, input hi, input skip, input [7:0] d);
        begin
            apb(1'b1, `REG_DATA, {24'h0, d});
            apb(1'b1, `REG_CTRL, {23'h0, skip, 1'b0, hi, a, 1'b0, o});
            wait_idle;
        end
    endtask
    function exp_refused(input [7:0] c, input erased);
        exp_refused = (c == `CMD_WRITE_FLASH || c == `CMD_WRITE_EEPROM) && !erased;
    endfunction
    // writing commands before and after erase; after erase the last one left is write flash
    task cmd_loop(input erased);
        for (i = 0; i < 3; i = i + 1) begin
            b = (i == 0) ? `CMD_WRITE_FUSE : (i == 1) ? `CMD_WRITE_EEPROM : `CMD_WRITE_FLASH;
            op(`OP_LOAD, `ACT_CMD, 1'b0, 1'b0, b);
            st;
            check(rd[`ST_REFUSED], exp_refused(b, erased), "cmd refuse");
            apb(1'b1, `REG_STATUS, 32'hc0);
        end
    endtask
    // ***
    // main sequence
    // ***
    initial begin
        {psel, penable, pwrite, presetn, paddr, pwdata} = 44'h0;
        {fail_count, n_checks, w, seed} = {32'h0, 32'h0, 32'h0, 32'd73882};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({reset_low, write_strobe_n, data_oe_n, output_enable_n, vcc_en}, 5'h1e, "idle");
        apb(1'b0, `REG_CTRL, 32'h0);
        check(rd, 32'h0, "ctrl reset");
        apb(1'b0, 8'h10, 32'h0);
        check(err, 1'b1, "unmapped");
        op(`OP_LOAD, `ACT_CMD, 1'b0, 1'b0, `CMD_CHIP_ERASE);
        st;
        check(rd[`ST_REFUSED], 1'b1, "no mode");
        apb(1'b1, `REG_STATUS, 32'hc0);
        op(`OP_ALT_ENTER, 2'h0, 1'b0, 1'b0, 8'h00);
        st;
        check({rd[4:1], mdl.in_mode}, 5'h17, "alt entry");
        op(`OP_LOAD, `ACT_CMD, 1'b0, 1'b0, `CMD_WRITE_FLASH);
        st;
        check(rd[`ST_REFUSED], 1'b1, "alt refuse");
        op(`OP_EXIT, 2'h0, 1'b0, 1'b0, 8'h00);
        check({reset_low, reset_hv_en, mdl.in_mode}, 3'h4, "exit");
        apb(1'b1, `REG_STATUS, 32'hc0);
        apb(1'b1, `REG_CTRL, 32'h0);
        apb(1'b1, `REG_CTRL, 32'h0);
        wait_idle;
        check({rd[`ST_OVERRUN], rd[`ST_ALT], rd[`ST_IN_MODE], mdl.in_mode}, 4'hb, "entry");
        apb(1'b1, `REG_STATUS, 32'hc0);
        cmd_loop(1'b0);
        op(`OP_LOAD, `ACT_CMD, 1'b0, 1'b0, `CMD_CHIP_ERASE);
        check(mdl.cmd, `CMD_CHIP_ERASE, "erase cmd");
        op(`OP_WRITE, `ACT_IDLE, 1'b0, 1'b0, 8'h00);
        st;
        check({rd[`ST_ERASED], rd[`ST_BUSY], mdl.lock_bits, mdl.n_erase[3:0]}, 7'h41, "erase");
        cmd_loop(1'b1);
        for (i = 0; i < 8; i = i + 1) begin
            r = $random(seed);
            op(`OP_LOAD, {1'b0, r[8]}, r[9], 1'b0, r[7:0]);
            b = r[8] ? mdl.dat : r[9] ? mdl.addr_hi : mdl.addr_lo;
            check(b, r[7:0], "load byte");
        end
        apb(1'b0, `REG_RETAIN, 32'h0);
        check({rd[31:24], rd[0], mdl.cmd}, 17'h02110, "retained");
        check({rd[23:8], rd[6:1]}, {mdl.addr_hi, mdl.addr_lo, mdl.addr_lo[5:0]}, "address");
        nl = mdl.n_loads;
        op(`OP_LOAD, `ACT_DATA, 1'b0, 1'b1, `DATA_ERASED);
        st;
        check({rd[`ST_SKIPPED], mdl.n_loads[3:0] - nl[3:0]}, 5'h10, "skip ff");
        op(`OP_PAGE_LOAD, 2'h0, 1'b0, 1'b0, 8'h00);
        check({rd[`ST_REFUSED], page_load_strobe}, 2'h0, "page load");
        op(`OP_EXIT, 2'h0, 1'b0, 1'b0, 8'h00);
        check(mdl.in_mode, 1'b0, "exit 2");
        report_and_stop;
    end
endmodule

// >>> dv/prog_dev_model.sv
// behavioural device answering the parallel programming pins
`timescale 1ns/1ps
module prog_dev_model (
    input wire pclk,
    input wire vcc_en,
    input wire reset_low,
    input wire reset_hv_en,
    input wire load_pulse_input,
    input wire action_select_hi,
    input wire action_select_lo,
    input wire low_high_byte_select,
    input wire page_load_strobe,
    input wire write_strobe_n,
    input wire data_oe_n,
    input wire [7:0] data_out,
    output reg [7:0] data_in,
    output reg ready_busy_flag
);
    wire [3:0] pins = {page_load_strobe, action_select_hi, action_select_lo, low_high_byte_select};
    wire [7:0] bus = data_oe_n ? ~data_out : data_out; // a released bus reads as garbage
    reg in_mode, lock_bits, hv_q, vcc_q, lp_q, wr_q;
    reg [3:0] pins_q;
    reg [7:0] cmd, addr_lo, addr_hi, dat;
    integer n_loads, n_erase, toggles, busy_cnt, hv_t;
    initial begin
        {in_mode, hv_q, vcc_q, lp_q, pins_q} = 8'h00;
        {lock_bits, wr_q, ready_busy_flag} = 3'h7;
        {cmd, addr_lo, addr_hi, dat} = 32'h0;
        data_in = 8'h5a;
        {n_loads, n_erase, toggles, busy_cnt, hv_t} = 160'h0;
    end
    // entry, exit and erase; the device never drives data, so data_in churns
    always @(posedge pclk) begin
        data_in <= ~data_in;
        {hv_q, vcc_q, lp_q, wr_q, pins_q} <= {reset_hv_en, vcc_en, load_pulse_input, write_strobe_n, pins};
        hv_t <= reset_hv_en ? hv_t + 1 : 0;
        if (reset_hv_en) toggles <= 0;
        else if (reset_low && lp_q != load_pulse_input) toggles <= toggles + 1;
        if (reset_low || !vcc_en) in_mode <= 1'b0;
        else if (reset_hv_en && !hv_q) in_mode <= pins == 4'h0 && (toggles >= 6 || !vcc_q);
        else if (hv_t < 25 && pins != pins_q) in_mode <= 1'b0;
        if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
        if (busy_cnt == 1) lock_bits <= 1'b0;
        ready_busy_flag <= busy_cnt == 0;
        if (in_mode && wr_q && !write_strobe_n && cmd == 8'h80) begin
            busy_cnt <= 300;
            n_erase <= n_erase + 1;
        end
    end
    // loads taken on the rising edge of the load pulse
    always @(posedge load_pulse_input) begin
        if (in_mode) begin
            n_loads <= n_loads + 1;
            case ({action_select_hi, action_select_lo})
                2'h0: begin
                    if (low_high_byte_select) addr_hi <= bus;
                    else addr_lo <= bus;
                end
                2'h1: dat <= bus;
                2'h2: if (!low_high_byte_select) cmd <= bus;
                default: ;
            endcase
        end
    end
endmodule

// >>> dv/prog_port_checker_assertions.sv
// checker on the programming pins of the controller
`timescale 1ns/1ps
module prog_port_checker (
    input wire pclk,
    input wire presetn,
    input wire vcc_en,
    input wire reset_low,
    input wire reset_hv_en,
    input wire load_pulse_input,
    input wire action_select_hi,
    input wire action_select_lo,
    input wire low_high_byte_select,
    input wire page_load_strobe,
    input wire write_strobe_n,
    input wire [7:0] data_out,
    input wire data_oe_n
);
    wire [3:0] pins = {page_load_strobe, action_select_hi, action_select_lo, low_high_byte_select};
    reg [5:0] hv_cnt;
    reg [6:0] lo_cnt;
    // saturating counts, so a long phase cannot wrap into a false failure
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hv_cnt <= 6'h00;
            lo_cnt <= 7'h00;
        end else begin
            hv_cnt <= reset_hv_en ? hv_cnt + {5'h00, hv_cnt != 6'h3f} : 6'h00;
            lo_cnt <= write_strobe_n ? 7'h00 : lo_cnt + {6'h00, lo_cnt != 7'h7f};
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_hv_rise;
        $rose(reset_hv_en);
    endsequence
    sequence s_pins_quiet;
        pins == 4'h0 && $past(pins, 25) == 4'h0;
    endsequence
    AST_ENTRY_ZERO: assert property (s_hv_rise |-> s_pins_quiet)
        else $error("entry pins not zero before high voltage");
    AST_ENTRY_HELD: assert property (reset_hv_en && hv_cnt < 6'h19 |-> $stable(pins))
        else $error("entry pins moved after high voltage");
    AST_HV_SUPPLY: assert property (reset_hv_en |-> !reset_low && vcc_en)
        else $error("high voltage with reset low or no supply");
    AST_EXIT: assert property ($fell(reset_hv_en) |-> reset_low)
        else $error("exit left reset released");
    AST_WR_WIDTH: assert property ($rose(write_strobe_n) |-> lo_cnt >= 7'h3f)
        else $error("write strobe too short");
    AST_WR_IN_MODE: assert property (!write_strobe_n |-> reset_hv_en)
        else $error("write strobe outside mode");
    AST_LOAD_STEADY: assert property (load_pulse_input && !data_oe_n |-> $stable({pins, data_out}))
        else $error("load inputs moved during pulse");
    AST_CMD_LOW: assert property (load_pulse_input && action_select_hi && !action_select_lo
        |-> !low_high_byte_select) else $error("command load with high byte");
endmodule
bind prog_port_ctrl prog_port_checker chk (.*);

// >>> inc/prog_port_regs.vh
// constants of the parallel programming port controller
// Function
// - hold reset low and toggle the load pulse input six times first
// - drive entry pins to zero at least 100 ns before high voltage
// - keep entry pins steady for 100 ns after high voltage
// - fallback entry: pins zero, supply and high voltage together, wait 100 us
// - after fallback entry rewrite clock source fuses, then re-enter normally
// - with lock bits programmed, chip erase before any fuse write
// - programming mode ends on power down or reset driven to zero
// - after chip erase, writing all-ones values may be skipped
// - reload address high byte only for a new 256 window
// - chip erase must precede reprogramming flash or eeprom
// - command load: action 10, byte select 0, data, positive load pulse
// - wait for ready busy high before loading a new command
// - entry pins: page load strobe, both action bits, byte select, all 0
`ifndef PROG_PORT_REGS_VH
`define PROG_PORT_REGS_VH

// ********
// register map
// ********
`define REG_CTRL 8'h00
`define REG_DATA 8'h04
`define REG_STATUS 8'h08
`define REG_RETAIN 8'h0c

// ctrl fields
`define CTRL_OP_LSB 0
`define CTRL_ACT_LSB 4
`define CTRL_BYTE_HI 6
`define CTRL_SKIP_EN 8
`define CTRL_LOCK_SET 9
`define CTRL_RESET 10'h000

// status fields
`define ST_BUSY 0
`define ST_IN_MODE 1
`define ST_RDY 2
`define ST_ERASED 3
`define ST_ALT 4
`define ST_SKIPPED 5
`define ST_REFUSED 6
`define ST_OVERRUN 7
`define ST_DIN_LSB 8

// ********
// operations, actions, commands
// ********
`define OP_ENTER 3'h0
`define OP_ALT_ENTER 3'h1
`define OP_EXIT 3'h2
`define OP_LOAD 3'h3
`define OP_WRITE 3'h4
`define OP_PAGE_LOAD 3'h5

`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
`define ACT_IDLE 2'h3

`define CMD_CHIP_ERASE 8'h80
`define CMD_WRITE_FUSE 8'h40
`define CMD_WRITE_FLASH 8'h10
`define CMD_WRITE_EEPROM 8'h11
`define DATA_ERASED 8'hff

// ********
// timing
// ********
`define CLK_NS 4
`define PULSE_NS 250
`define ENTRY_SETUP_NS 100
`define ENTRY_HOLD_NS 100
`define ALT_WAIT_US 100
`define SETTLE_NS 250
`define ENTRY_TOGGLES 6
`define PULSE_CYC ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define ENTRY_SETUP_CYC ((`ENTRY_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define ENTRY_HOLD_CYC ((`ENTRY_HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define ALT_WAIT_CYC ((`ALT_WAIT_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define TIMER_W 16

`endif

// >>> verilog/cycle_timer.v
// down counter that times each phase of the pin sequence except the ready busy waits
`timescale 1ns/1ps
`include "prog_port_regs.vh"

module cycle_timer (
    input wire pclk,
    input wire presetn,
    input wire load,
    input wire [`TIMER_W-1:0] count,
    output wire expired
);

reg [`TIMER_W-1:0] cnt_reg;

// a load in flight hides the stale zero of the previous phase
assign expired = (cnt_reg == {`TIMER_W{1'b0}}) && !load;

// ********
// counter
// ********
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt_reg <= {`TIMER_W{1'b0}};
    end else if (load) begin
        cnt_reg <= count;
    end else if (cnt_reg != {`TIMER_W{1'b0}}) begin
        cnt_reg <= cnt_reg - {{(`TIMER_W-1){1'b0}}, 1'b1};
    end
end

endmodule

// >>> verilog/prog_port_ctrl.v
// apb controlled programmer that drives the parallel programming pins
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "prog_port_regs.vh"

module prog_port_ctrl #(
    parameter [`TIMER_W-1:0] ALT_WAIT_CYC = `ALT_WAIT_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg vcc_en,
    output reg reset_low,
    output reg reset_hv_en,
    output reg load_pulse_input,
    output reg action_select_hi,
    output reg action_select_lo,
    output reg low_high_byte_select,
    output reg page_load_strobe,
    output reg write_strobe_n,
    output reg output_enable_n,
    output reg [7:0] data_out,
    output reg data_oe_n,
    input wire [7:0] data_in,
    input wire ready_busy_flag
);

localparam [3:0] S_IDLE = 4'h0;
localparam [3:0] S_TOG = 4'h1;
localparam [3:0] S_PINS = 4'h2;
localparam [3:0] S_HOLD = 4'h3;
localparam [3:0] S_ALT = 4'h4;
localparam [3:0] S_RDY = 4'h5;
localparam [3:0] S_SET = 4'h6;
localparam [3:0] S_XHI = 4'h7;
localparam [3:0] S_XLO = 4'h8;
localparam [3:0] S_WRLO = 4'h9;
localparam [3:0] S_SETTLE = 4'ha;
localparam [3:0] S_BUSY = 4'hb;
localparam [3:0] S_PGHI = 4'hc;
localparam [3:0] S_EXIT = 4'hd;
localparam [`TIMER_W-1:0] T_PULSE = `PULSE_CYC;
localparam [`TIMER_W-1:0] T_SETUP = `ENTRY_SETUP_CYC;
localparam [`TIMER_W-1:0] T_HOLD = `ENTRY_HOLD_CYC;
localparam [`TIMER_W-1:0] T_SETTLE = `SETTLE_CYC;
localparam [3:0] TOG_LAST = 2 * `ENTRY_TOGGLES - 1;

reg [9:0] ctrl_reg;
reg [7:0] data_reg;
reg [3:0] state_reg;
reg [3:0] tog_reg;
reg tmr_load_reg;
reg [`TIMER_W-1:0] tmr_count_reg;
reg in_mode_reg, alt_reg, erased_reg;
reg cmd_valid_reg, addr_hi_valid_reg;
reg [7:0] cmd_reg, addr_lo_reg, addr_hi_reg;
reg skipped_reg, refused_reg, overrun_reg;
reg go_reg;
reg rdy_s1_reg, rdy_s2_reg;
reg [7:0] din_s1_reg, din_s2_reg;
reg refuse_now, skip_now;
reg [31:0] rd_mux;
wire tmr_expired;
wire setup_ph = psel && !penable;
wire access_ok = psel && penable && pready;
wire [2:0] op = ctrl_reg[`CTRL_OP_LSB +: 3];
wire [1:0] act = ctrl_reg[`CTRL_ACT_LSB +: 2];
wire byte_hi = ctrl_reg[`CTRL_BYTE_HI];
wire skip_en = ctrl_reg[`CTRL_SKIP_EN];
wire lock_set = ctrl_reg[`CTRL_LOCK_SET];
wire [12:0] word_addr = {addr_hi_reg[4:0], addr_lo_reg};

// true only for the four register offsets of the map
function addr_ok;
    input [7:0] a;
    begin
        addr_ok = (a == `REG_CTRL) || (a == `REG_DATA) ||
                  (a == `REG_STATUS) || (a == `REG_RETAIN);
    end
endfunction

// page number and word within page of a flash word address
function [6:0] page_of;
    input [12:0] a;
    begin
        page_of = a[12:6];
    end
endfunction

function [5:0] word_of;
    input [12:0] a;
    begin
        word_of = a[5:0];
    end
endfunction

// commands that rewrite flash or eeprom contents
function is_mem_write;
    input [7:0] c;
    begin
        is_mem_write = (c == `CMD_WRITE_FLASH) || (c == `CMD_WRITE_EEPROM);
    end
endfunction

cycle_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(tmr_load_reg),
    .count(tmr_count_reg),
    .expired(tmr_expired)
);

// ********
// pin input synchronisers
// ********
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        {rdy_s1_reg, rdy_s2_reg} <= 2'h0;
        {din_s1_reg, din_s2_reg} <= 16'h0000;
    end else begin
        rdy_s1_reg <= ready_busy_flag;
        rdy_s2_reg <= rdy_s1_reg;
        din_s1_reg <= data_in;
        din_s2_reg <= din_s1_reg;
    end
end

// ********
// load request checks
// ********
always @* begin
    refuse_now = 1'b0;
    skip_now = 1'b0;
    if (!in_mode_reg) begin
        refuse_now = 1'b1;
    end else if (act == `ACT_CMD) begin
        if (data_reg == `CMD_WRITE_FUSE && lock_set && !erased_reg) begin
            refuse_now = 1'b1;
        end else if (is_mem_write(data_reg) && !erased_reg) begin
            refuse_now = 1'b1;
        end else if (alt_reg && data_reg != `CMD_WRITE_FUSE &&
                     data_reg != `CMD_CHIP_ERASE) begin
            refuse_now = 1'b1;
        end else if (skip_en && cmd_valid_reg && data_reg == cmd_reg) begin
            skip_now = 1'b1;
        end
    end else if (act == `ACT_ADDR && byte_hi) begin
        if (skip_en && addr_hi_valid_reg && data_reg == addr_hi_reg) begin
            skip_now = 1'b1;
        end
    end else if (act == `ACT_DATA) begin
        if (skip_en && erased_reg && data_reg == `DATA_ERASED) begin
            skip_now = 1'b1;
        end
    end
end

// ********
// read mux
// ********
always @* begin
    rd_mux = 32'h0000_0000;
    if (paddr == `REG_CTRL) begin
        rd_mux[9:0] = ctrl_reg;
    end else if (paddr == `REG_DATA) begin
        rd_mux[7:0] = data_reg;
    end else if (paddr == `REG_STATUS) begin
        rd_mux[`ST_BUSY] = (state_reg != S_IDLE) || go_reg;
        rd_mux[`ST_IN_MODE] = in_mode_reg;
        rd_mux[`ST_RDY] = rdy_s2_reg;
        rd_mux[`ST_ERASED] = erased_reg;
        rd_mux[`ST_ALT] = alt_reg;
        rd_mux[`ST_SKIPPED] = skipped_reg;
        rd_mux[`ST_REFUSED] = refused_reg;
        rd_mux[`ST_OVERRUN] = overrun_reg;
        rd_mux[`ST_DIN_LSB +: 8] = din_s2_reg;
    end else if (paddr == `REG_RETAIN) begin
        rd_mux = {cmd_reg, addr_hi_reg, addr_lo_reg,
                  page_of(word_addr), cmd_valid_reg};
        rd_mux[6:1] = word_of(word_addr);
    end
end

// ********
// apb slave: answer in the first access cycle
// ********
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
        ctrl_reg <= `CTRL_RESET;
        data_reg <= 8'h00;
        go_reg <= 1'b0;
    end else begin
        pready <= setup_ph;
        pslverr <= setup_ph && !addr_ok(paddr);
        prdata <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
        go_reg <= 1'b0;
        if (access_ok && pwrite && state_reg == S_IDLE && !go_reg) begin
            // the ctrl write itself launches the operation
            if (paddr == `REG_CTRL) begin
                ctrl_reg <= pwdata[9:0];
                go_reg <= 1'b1;
            end else if (paddr == `REG_DATA) begin
                data_reg <= pwdata[7:0];
            end
        end
    end
end

// ********
// sequencer and device pins
// ********
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_reg <= S_IDLE;
        tog_reg <= 4'h0;
        tmr_load_reg <= 1'b0;
        tmr_count_reg <= {`TIMER_W{1'b0}};
        {in_mode_reg, alt_reg, erased_reg, cmd_valid_reg, addr_hi_valid_reg} <= 5'h00;
        {cmd_reg, addr_lo_reg, addr_hi_reg} <= 24'h000000;
        {skipped_reg, refused_reg, overrun_reg} <= 3'h0;
        {vcc_en, reset_hv_en, load_pulse_input, action_select_hi} <= 4'h0;
        {action_select_lo, low_high_byte_select, page_load_strobe} <= 3'h0;
        {reset_low, write_strobe_n, output_enable_n, data_oe_n} <= 4'hf;
        data_out <= 8'h00;
    end else begin
        tmr_load_reg <= 1'b0;
        // sticky errors: w1c clear, a new event in the same cycle wins
        if (access_ok && pwrite && paddr == `REG_STATUS) begin
            if (pwdata[`ST_REFUSED]) refused_reg <= 1'b0;
            if (pwdata[`ST_OVERRUN]) overrun_reg <= 1'b0;
        end
        if (access_ok && pwrite && paddr == `REG_CTRL &&
            (state_reg != S_IDLE || go_reg)) begin
            overrun_reg <= 1'b1;
        end
        case (state_reg)
        S_IDLE: begin
            if (go_reg) begin
                skipped_reg <= 1'b0;
                tmr_load_reg <= 1'b1;
                tmr_count_reg <= T_PULSE;
                if (op == `OP_ENTER) begin
                    // pins zero from the start, reset held low
                    vcc_en <= 1'b1;
                    reset_low <= 1'b1;
                    reset_hv_en <= 1'b0;
                    {page_load_strobe, action_select_hi} <= 2'b00;
                    {action_select_lo, low_high_byte_select} <= 2'b00;
                    tog_reg <= 4'h0;
                    state_reg <= S_TOG;
                end else if (op == `OP_ALT_ENTER) begin
                    {page_load_strobe, action_select_hi} <= 2'b00;
                    {action_select_lo, low_high_byte_select} <= 2'b00;
                    vcc_en <= 1'b1;
                    reset_low <= 1'b0;
                    reset_hv_en <= 1'b1;
                    tmr_count_reg <= ALT_WAIT_CYC;
                    state_reg <= S_ALT;
                end else if (op == `OP_EXIT) begin
                    reset_hv_en <= 1'b0;
                    reset_low <= 1'b1;
                    in_mode_reg <= 1'b0;
                    alt_reg <= 1'b0;
                    state_reg <= S_EXIT;
                end else if (!in_mode_reg ||
                             (op == `OP_LOAD && (refuse_now || skip_now))) begin
                    // refused or redundant: nothing reaches the pins
                    refused_reg <= refused_reg | refuse_now | !in_mode_reg;
                    skipped_reg <= skip_now && in_mode_reg;
                    tmr_load_reg <= 1'b0;
                end else if (op == `OP_LOAD) begin
                    state_reg <= (act == `ACT_CMD) ? S_RDY : S_SET;
                    tmr_load_reg <= (act != `ACT_CMD);
                    action_select_hi <= act[1];
                    action_select_lo <= act[0];
                    low_high_byte_select <= byte_hi && act != `ACT_CMD;
                    data_out <= data_reg;
                    data_oe_n <= 1'b0;
                end else if (op == `OP_WRITE) begin
                    write_strobe_n <= 1'b0;
                    state_reg <= S_WRLO;
                end else if (op == `OP_PAGE_LOAD) begin
                    page_load_strobe <= 1'b1;
                    state_reg <= S_PGHI;
                end else begin
                    refused_reg <= 1'b1;
                    tmr_load_reg <= 1'b0;
                end
            end
        end
        S_TOG: begin
            if (tmr_expired) begin
                load_pulse_input <= !load_pulse_input;
                tog_reg <= tog_reg + 4'h1;
                tmr_load_reg <= 1'b1;
                tmr_count_reg <= T_PULSE;
                if (tog_reg == TOG_LAST) begin
                    tmr_count_reg <= T_SETUP;
                    state_reg <= S_PINS;
                end
            end
        end
        S_PINS: begin
            if (tmr_expired) begin
                reset_low <= 1'b0;
                reset_hv_en <= 1'b1;
                tmr_load_reg <= 1'b1;
                tmr_count_reg <= T_HOLD;
                state_reg <= S_HOLD;
            end
        end
        S_HOLD, S_ALT: begin
            // entry pins stay untouched for the whole hold
            if (tmr_expired) begin
                in_mode_reg <= 1'b1;
                alt_reg <= (state_reg == S_ALT);
                erased_reg <= 1'b0;
                cmd_valid_reg <= 1'b0;
                addr_hi_valid_reg <= 1'b0;
                state_reg <= S_IDLE;
            end
        end
        S_RDY: begin
            if (rdy_s2_reg) begin
                tmr_load_reg <= 1'b1;
                tmr_count_reg <= T_PULSE;
                state_reg <= S_SET;
            end
        end
        S_SET: begin
            // pins settle one pulse width before the rising edge
            if (tmr_expired) begin
                load_pulse_input <= 1'b1;
                tmr_load_reg <= 1'b1;
                tmr_count_reg <= T_PULSE;
                state_reg <= S_XHI;
            end
        end
        S_XHI: begin
            if (tmr_expired) begin
                load_pulse_input <= 1'b0;
                tmr_load_reg <= 1'b1;
                tmr_count_reg <= T_PULSE;
                state_reg <= S_XLO;
                if (act == `ACT_CMD) begin
                    cmd_reg <= data_out;
                    cmd_valid_reg <= 1'b1;
                end else if (act == `ACT_ADDR && low_high_byte_select) begin
                    addr_hi_reg <= data_out;
                    addr_hi_valid_reg <= 1'b1;
                end else if (act == `ACT_ADDR) begin
                    addr_lo_reg <= data_out;
                end
            end
        end
        S_XLO: begin
            // hold pins after the fall, then park the action as idle
            if (tmr_expired) begin
                action_select_hi <= 1'b1;
                action_select_lo <= 1'b1;
                data_oe_n <= 1'b1;
                state_reg <= S_IDLE;
            end
        end
        S_WRLO: begin
            if (tmr_expired) begin
                write_strobe_n <= 1'b1;
                tmr_load_reg <= 1'b1;
                tmr_count_reg <= T_SETTLE;
                state_reg <= S_SETTLE;
            end
        end
        S_SETTLE: begin
            // gives ready busy time to fall and cross the synchroniser
            if (tmr_expired) begin
                state_reg <= S_BUSY;
            end
        end
        S_BUSY: begin
            if (rdy_s2_reg) begin
                if (cmd_reg == `CMD_CHIP_ERASE) begin
                    erased_reg <= 1'b1;
                    alt_reg <= alt_reg;
                end
                state_reg <= S_IDLE;
            end
        end
        S_PGHI: begin
            if (tmr_expired) begin
                page_load_strobe <= 1'b0;
                state_reg <= S_IDLE;
            end
        end
        S_EXIT: begin
            if (tmr_expired) begin
                action_select_hi <= 1'b0;
                action_select_lo <= 1'b0;
                state_reg <= S_IDLE;
            end
        end
        default: begin
            state_reg <= S_IDLE;
        end
        endcase
    end
end

endmodule
